// ==== verilog/mfc_pkg.sv ====
package mfc_pkg;

  // ------------------------------------------------------------------
  // clock and pin timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned T_WP_NS       = 15;
  localparam int unsigned T_WC_NS       = 33;
  localparam int unsigned T_REA_NS      = 20;
  localparam int unsigned T_RC_NS       = 35;
  localparam int unsigned T_WB_NS       = 100;
  localparam int unsigned T_WHR_NS      = 50;
  localparam int unsigned T_RR_NS       = 20;
  localparam int unsigned T_R_US        = 120;

  localparam int unsigned WP_CYC     = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WC_CYC     = (T_WC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RD_LOW_CYC = (T_REA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int unsigned RC_CYC     = (T_RC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WB_CYC     = (T_WB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WHR_CYC    = (T_WHR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RR_CYC     = (T_RR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TR_MAX_CYC = (T_R_US * 1000000) / CLK_PERIOD_PS;

  // ------------------------------------------------------------------
  // command codes and limits
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_STATUS_BASE = 8'h70;
  localparam logic [7:0] CMD_STATUS_LAST = 8'h76;
  localparam logic [7:0] CMD_RESET       = 8'hff;
  localparam logic [7:0] CMD_PROG_LOAD   = 8'h80;
  localparam logic [7:0] CMD_RAND_IN     = 8'h85;
  localparam logic [7:0] CMD_PROG_GO     = 8'h10;
  localparam logic [7:0] CMD_PROG_MULTI  = 8'h11;
  localparam logic [7:0] CMD_PROG_CACHE  = 8'h15;
  localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
  localparam logic [7:0] CMD_READ_GO     = 8'h30;
  localparam logic [7:0] CMD_RAND_OUT    = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_GO = 8'he0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO    = 8'hd0;

  localparam int unsigned ADDR_CYCLES = 4;
  localparam int unsigned MAX_BANKS   = 4;
  localparam int unsigned MAX_RAND_IN = 3;
  localparam int unsigned STATUS_SELS = 7;
  localparam int unsigned FIFO_WORDS  = 8;

  typedef enum logic [2:0] {
    OP_STATUS   = 3'h0,
    OP_RESET    = 3'h1,
    OP_READ     = 3'h2,
    OP_RAND_OUT = 3'h3,
    OP_LOAD     = 3'h4,
    OP_RAND_IN  = 3'h5,
    OP_CONFIRM  = 3'h6,
    OP_ERASE    = 3'h7
  } mfc_op_t;

endpackage

// ==== verilog/mfc_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module mfc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem_r[rp_r];

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + CW'(1);
    else if (pop && !push)
      cnt_nxt = cnt_r - CW'(1);
  end

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  // ------------------------------------------------------------------
  // pointers and flags
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_r      <= '0;
      rp_r      <= '0;
      cnt_r     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + AW'(1);
      if (pop)
        rp_r <= rp_r + AW'(1);
      cnt_r     <= cnt_nxt;
      in_ready  <= cnt_nxt != CW'(DEPTH);
      out_valid <= cnt_nxt != '0;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/mfc_host.sv ====
// Overview of operation
// R1: a page read must reach ready within 120 us, else timeout.
// R2: status code 70h gives status, 72h single-bank error status.
// R3: status code 71h gives combined multi-bank status.
// R4: codes 73h to 76h give error status of banks 0 to 3.
// R5: multi-bank read or program chains at most four bank setups.
// R6: random data output may restart at a new column any number of times.
// R7: random data input may repeat freely before the program confirm.
// R8: multi-bank program allows at most three random data inputs; the host counts only those issued after the chain's first 11h confirm.
// R9: cache program chains have no length limit.
// R10: consecutive cache program pages must not share a bank.
// R11: copy-back data may be overwritten before the destination program.
// R12: multi-bank copy-back names at most four source banks.
// R13: multi-bank erase or erase verify names at most four banks.
// R14: device releases data pins when chip enable or read strobe rises.
// R15: while busy only status reads or reset may be issued.
// R16: after 80h or 85h only 10h, 11h, 15h or FFh may follow; the host also accepts 85h there.
// R17: every address is exactly four address cycles.
// R18: device holds ready/busy low during internal operations.
// R19: array data is strobed out only after ready returns.
`timescale 1ns/100ps
`default_nettype none
module mfc_host
  import mfc_pkg::*;
#(
  parameter int unsigned TR_CYC     = TR_MAX_CYC,
  parameter int unsigned FIFO_DEPTH = FIFO_WORDS,
  parameter int unsigned LEN_W      = 12
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             cmd_valid,
  input  wire mfc_op_t          cmd_op,
  input  wire logic [2:0]       cmd_sel,
  input  wire logic [1:0]       cmd_bank,
  input  wire logic [31:0]      cmd_addr,
  input  wire logic [LEN_W-1:0] cmd_len,
  output logic                  cmd_ready,
  output logic                  cmd_err,
  output logic                  busy_timeout,
  input  wire logic             wr_valid,
  input  wire logic [7:0]       wr_data,
  output logic                  wr_ready,
  output logic      [7:0]       rd_data,
  output logic                  rd_valid,
  output logic                  ce_n,
  output logic                  cle,
  output logic                  ale,
  output logic                  we_n,
  output logic                  read_strobe_n,
  output logic      [7:0]       io_out,
  output logic                  io_oe,
  input  wire logic [7:0]       io_in,
  input  wire logic             ready_busy,
  output logic                  deep_standby_reset_n
);
  localparam int unsigned WW = $clog2(TR_CYC + 1);

  if (TR_CYC < WHR_CYC || TR_CYC < WB_CYC || LEN_W < 1) begin : g_bad_param
    $error("read timeout or length width too small");
  end

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CMD1 = 9'h002,
    ST_ADDR = 9'h004,
    ST_DATA = 9'h008,
    ST_CMD2 = 9'h010,
    ST_WB   = 9'h020,
    ST_RDY  = 9'h040,
    ST_GAP  = 9'h080,
    ST_READ = 9'h100
  } mfc_st_t;

  mfc_st_t          st_r;
  mfc_st_t          st_nxt;
  mfc_op_t          op_r;
  logic [2:0]       sel_r;
  logic [3:0][7:0]  addr_r;
  logic [1:0]       idx_r;
  logic [LEN_W-1:0] len_r;
  logic [3:0]       cyc_r;
  logic [WW-1:0]    wait_r;
  logic             prog_open_r;
  logic [1:0]       multi_cnt_r;
  logic [1:0]       randin_cnt_r;
  logic [1:0]       last_bank_r;
  logic [1:0]       cache_bank_r;
  logic             cache_vld_r;
  logic [2:0]       ale_cnt_r;
  logic             fifo_valid;
  logic [7:0]       fifo_data;
  logic [7:0]       code1;
  logic [7:0]       code2;
  logic [7:0]       byte_out;
  logic             take;
  logic             refuse;
  logic             accept;
  logic             wr_busy;
  logic             wr_go;
  logic             wend;
  logic             rd_go;
  logic             rd_samp;
  logic             rend;
  logic             rd_expired;

  // ------------------------------------------------------------------
  // program data buffer
  // ------------------------------------------------------------------
  mfc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (wr_go && st_r == ST_DATA)
  );

  // ------------------------------------------------------------------
  // command acceptance
  // ------------------------------------------------------------------
  assign take = cmd_valid && cmd_ready;

  always_comb
  begin
    refuse = 1'b0;
    // R15: busy gate
    if (!ready_busy && !(cmd_op inside {OP_STATUS, OP_RESET}))
      refuse = 1'b1;
    // R16: open program gate, random input stays legal
    if (prog_open_r && !(cmd_op inside {OP_CONFIRM, OP_RESET, OP_RAND_IN}))
      refuse = 1'b1;
    if (cmd_op inside {OP_READ, OP_RAND_OUT, OP_LOAD, OP_RAND_IN} && cmd_len == '0)
      refuse = 1'b1;
    if (cmd_op == OP_STATUS && 32'(cmd_sel) >= STATUS_SELS)
      refuse = 1'b1;
    if (cmd_op == OP_CONFIRM)
    begin
      if (!prog_open_r || cmd_sel > 3'h2)
        refuse = 1'b1;
      // R5: bank setup limit
      if (cmd_sel == 3'h1 && multi_cnt_r == 2'(MAX_BANKS - 1))
        refuse = 1'b1;
      // R10: cache bank clash
      if (cmd_sel == 3'h2 && cache_vld_r && cache_bank_r == last_bank_r)
        refuse = 1'b1;
    end
    // R13: erase bank limit
    if (cmd_op == OP_ERASE && cmd_sel[0] && multi_cnt_r == 2'(MAX_BANKS - 1))
      refuse = 1'b1;
    // R8: multi-bank random input limit
    if (cmd_op == OP_RAND_IN && multi_cnt_r != '0 && randin_cnt_r == 2'(MAX_RAND_IN))
      refuse = 1'b1;
  end

  assign accept = take && !refuse;

  // ------------------------------------------------------------------
  // command bytes
  // ------------------------------------------------------------------
  always_comb
  begin
    case (op_r)
      // R2: single-bank status and error codes
      // R3: multi-bank status code
      // R4: per-bank error codes
      OP_STATUS:   code1 = CMD_STATUS_BASE + {5'h00, sel_r};
      OP_RESET:    code1 = CMD_RESET;
      OP_READ:     code1 = CMD_READ_SETUP;
      // R6: column restart
      OP_RAND_OUT: code1 = CMD_RAND_OUT;
      OP_LOAD:     code1 = CMD_PROG_LOAD;
      // R7: repeatable data input
      // R11: copy-back overwrite
      OP_RAND_IN:  code1 = CMD_RAND_IN;
      // R9: cache chain uncapped
      OP_CONFIRM:  code1 = (sel_r == 3'h0) ? CMD_PROG_GO :
                           (sel_r == 3'h1) ? CMD_PROG_MULTI : CMD_PROG_CACHE;
      default:     code1 = CMD_ERASE_SETUP;
    endcase
    case (op_r)
      OP_READ:     code2 = CMD_READ_GO;
      OP_RAND_OUT: code2 = CMD_RAND_OUT_GO;
      default:     code2 = CMD_ERASE_GO;
    endcase
    case (st_r)
      ST_CMD1: byte_out = code1;
      ST_ADDR: byte_out = addr_r[idx_r];
      ST_DATA: byte_out = fifo_data;
      default: byte_out = code2;
    endcase
  end

  assign wr_busy    = st_r inside {ST_CMD1, ST_ADDR, ST_DATA, ST_CMD2};
  assign wr_go      = wr_busy && cyc_r == '0 && (st_r != ST_DATA || fifo_valid);
  assign wend       = wr_busy && cyc_r == 4'(WC_CYC - 1);
  assign rd_go      = st_r == ST_READ && cyc_r == '0;
  assign rd_samp    = st_r == ST_READ && cyc_r == 4'(RD_LOW_CYC);
  assign rend       = st_r == ST_READ && cyc_r == 4'(RC_CYC - 1);
  assign rd_expired = st_r == ST_RDY && op_r == OP_READ && !ready_busy &&
                      wait_r == WW'(TR_CYC - 1);

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
        if (accept)
          st_nxt = ST_CMD1;
      ST_CMD1:
        if (wend)
          st_nxt = (op_r == OP_STATUS) ? ST_GAP :
                   (op_r inside {OP_RESET, OP_CONFIRM}) ? ST_WB : ST_ADDR;
      ST_ADDR:
        // R17: exactly four address cycles
        if (wend && idx_r == 2'(ADDR_CYCLES - 1))
          st_nxt = (op_r inside {OP_LOAD, OP_RAND_IN}) ? ST_DATA :
                   (op_r == OP_ERASE && sel_r[0]) ? ST_IDLE : ST_CMD2;
      ST_DATA:
        if (wend && len_r == LEN_W'(1))
          st_nxt = ST_IDLE;
      ST_CMD2:
        if (wend)
          st_nxt = (op_r == OP_RAND_OUT) ? ST_GAP : ST_WB;
      ST_WB:
        if (wait_r == '0)
          st_nxt = ST_RDY;
      ST_RDY:
        // R18: hold until device ready
        // R19: strobe only after ready
        // R1: bounded page transfer
        if (ready_busy)
          st_nxt = (op_r == OP_READ) ? ST_GAP : ST_IDLE;
        else if (rd_expired)
          st_nxt = ST_IDLE;
      ST_GAP:
        if (wait_r == '0)
          st_nxt = ST_READ;
      ST_READ:
        if (rend && len_r == LEN_W'(1))
          st_nxt = ST_IDLE;
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r      <= ST_IDLE;
      op_r      <= OP_STATUS;
      sel_r     <= '0;
      addr_r    <= '0;
      cmd_ready <= 1'b0;
      cmd_err   <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      cmd_ready <= st_nxt == ST_IDLE && !take;
      cmd_err   <= take && refuse;
      if (accept)
      begin
        op_r   <= cmd_op;
        sel_r  <= cmd_sel;
        addr_r <= cmd_addr;
      end
    end
  end

  // ------------------------------------------------------------------
  // byte and cycle counters
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cyc_r <= '0;
      idx_r <= '0;
      len_r <= '0;
    end
    else if (accept)
    begin
      cyc_r <= '0;
      idx_r <= '0;
      len_r <= (cmd_op == OP_STATUS) ? LEN_W'(1) : cmd_len;
    end
    else if (wr_busy || st_r == ST_READ)
    begin
      if (wend || rend)
        cyc_r <= '0;
      else if (cyc_r != '0 || wr_go || rd_go)
        cyc_r <= cyc_r + 4'h1;
      if (wend && st_r == ST_ADDR)
        idx_r <= idx_r + 2'h1;
      if ((wend && st_r == ST_DATA) || rend)
        len_r <= len_r - LEN_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // wait timer
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_r       <= '0;
      busy_timeout <= 1'b0;
    end
    else
    begin
      busy_timeout <= rd_expired;
      if (st_nxt != st_r)
      begin
        if (st_nxt == ST_WB)
          wait_r <= WW'(WB_CYC - 1);
        else if (st_nxt == ST_GAP)
          wait_r <= (op_r == OP_READ) ? WW'(RR_CYC - 1) : WW'(WHR_CYC - 1);
        else
          wait_r <= '0;
      end
      else if (st_r inside {ST_WB, ST_GAP})
        wait_r <= wait_r - WW'(1);
      else if (st_r == ST_RDY)
        wait_r <= wait_r + WW'(1);
    end
  end

  // ------------------------------------------------------------------
  // program chain tracking
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prog_open_r  <= 1'b0;
      multi_cnt_r  <= '0;
      randin_cnt_r <= '0;
      last_bank_r  <= '0;
      cache_bank_r <= '0;
      cache_vld_r  <= 1'b0;
    end
    else if (accept)
    begin
      case (cmd_op)
        OP_LOAD:
        begin
          prog_open_r <= 1'b1;
          last_bank_r <= cmd_bank;
        end
        OP_RAND_IN:
        begin
          prog_open_r <= 1'b1;
          // R8: count inputs in a chain
          if (multi_cnt_r != '0)
            randin_cnt_r <= randin_cnt_r + 2'h1;
        end
        OP_CONFIRM:
        begin
          prog_open_r <= 1'b0;
          // R5: count bank setups
          // R12: copy-back banks share the count
          if (cmd_sel == 3'h1)
            multi_cnt_r <= multi_cnt_r + 2'h1;
          else
          begin
            multi_cnt_r  <= '0;
            randin_cnt_r <= '0;
          end
          cache_vld_r  <= cmd_sel == 3'h2;
          cache_bank_r <= last_bank_r;
        end
        OP_ERASE:
          multi_cnt_r <= cmd_sel[0] ? multi_cnt_r + 2'h1 : 2'h0;
        OP_RESET:
        begin
          prog_open_r  <= 1'b0;
          multi_cnt_r  <= '0;
          randin_cnt_r <= '0;
          cache_vld_r  <= 1'b0;
        end
        default:
          cache_vld_r <= cache_vld_r;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // flash pins
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ce_n                 <= 1'b1;
      cle                  <= 1'b0;
      ale                  <= 1'b0;
      we_n                 <= 1'b1;
      read_strobe_n        <= 1'b1;
      io_out               <= '0;
      io_oe                <= 1'b0;
      rd_data              <= '0;
      rd_valid             <= 1'b0;
      deep_standby_reset_n <= 1'b0;
    end
    else
    begin
      deep_standby_reset_n <= 1'b1;
      rd_valid             <= 1'b0;
      if (accept)
        ce_n <= 1'b0;
      else if (st_r == ST_IDLE)
        ce_n <= 1'b1;
      if (wr_go)
      begin
        io_out <= byte_out;
        io_oe  <= 1'b1;
        we_n   <= 1'b0;
        cle    <= st_r inside {ST_CMD1, ST_CMD2};
        ale    <= st_r == ST_ADDR;
      end
      else if (wend)
      begin
        io_oe <= 1'b0;
        cle   <= 1'b0;
        ale   <= 1'b0;
      end
      else if (wr_busy && cyc_r == 4'(WP_CYC))
        we_n <= 1'b1;
      // R14: bus left to device while reading
      if (rd_go)
        read_strobe_n <= 1'b0;
      else if (rd_samp)
      begin
        read_strobe_n <= 1'b1;
        rd_data       <= io_in;
        rd_valid      <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ale_cnt_r <= '0;
    else if (st_r == ST_IDLE)
      ale_cnt_r <= '0;
    else if (wr_go && st_r == ST_ADDR)
      ale_cnt_r <= ale_cnt_r + 3'h1;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  chk_busy_gate: // R15
    assert property (take && !ready_busy && !(cmd_op inside {OP_STATUS, OP_RESET})
                     |=> cmd_err && st_r == ST_IDLE)
    else $error("command taken while device busy");
  chk_prog_gate: // R16
    assert property (take && prog_open_r &&
                     !(cmd_op inside {OP_CONFIRM, OP_RESET, OP_RAND_IN})
                     |=> cmd_err && !cle)
    else $error("illegal command after program setup");
  chk_status_code: // R2
    assert property (st_r == ST_CMD1 && op_r == OP_STATUS && !we_n
                     |-> cle && io_out == CMD_STATUS_BASE + {5'h00, sel_r}
                         && io_out <= CMD_STATUS_LAST)
    else $error("bad status command byte");
  chk_bank_limit: // R5
    assert property (accept && cmd_op == OP_CONFIRM && cmd_sel == 3'h1
                     |=> multi_cnt_r == $past(multi_cnt_r) + 2'h1 && multi_cnt_r != 2'h0)
    else $error("bank chain count wrong");
  chk_randin_limit: // R8
    assert property (take && cmd_op == OP_RAND_IN && multi_cnt_r != 2'h0
                     && randin_cnt_r == 2'(MAX_RAND_IN) |=> cmd_err)
    else $error("too many random inputs in multi-bank program");
  chk_cache_bank: // R10
    assert property (take && cmd_op == OP_CONFIRM && cmd_sel == 3'h2
                     && cache_vld_r && cache_bank_r == last_bank_r |=> cmd_err)
    else $error("cache program repeated a bank");
  chk_addr_cycles: // R17
    assert property (st_r != ST_IDLE && st_nxt == ST_IDLE
                     |-> ale_cnt_r == 3'h0 || ale_cnt_r == 3'(ADDR_CYCLES))
    else $error("address phase not four cycles");
  chk_read_ready: // R19
    assert property (st_r == ST_RDY && op_r == OP_READ && ready_busy
                     |=> read_strobe_n [*5] ##1 !read_strobe_n)
    else $error("read strobe timing after ready wrong");
  chk_read_timeout: // R1
    assert property (rd_expired |=> busy_timeout && st_r == ST_IDLE ##1 ce_n)
    else $error("page transfer timeout not raised");
  chk_bus_release: // R14
    assert property (!read_strobe_n |-> !io_oe && !we_n == 1'b0)
    else $error("host drives bus during read strobe");
endmodule
`default_nettype wire

// ==== tb/mfc_flash_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mfc_flash_model (
  input  wire logic       ref_clk,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] io_out,
  input  wire logic       slow,
  output logic      [7:0] io_in,
  output logic            ready_busy
);
  logic [7:0] cmd = '0, col = '0, nb = '0, dat;
  logic       we_d = 1'h1, re_d = 1'h1;
  int         bsy = 0, ac = 0;
  assign dat = (cmd >= 8'h70 && cmd <= 8'h76) ? cmd ^ 8'h5a : col + nb;
  assign io_in = (ce_n || read_strobe_n) ? ~dat : dat;
  assign ready_busy = (bsy == 0);
  always @(posedge ref_clk)
  begin
    we_d <= we_n;
    re_d <= read_strobe_n;
    if (bsy > 0)
      bsy <= bsy - 1;
    // first address byte is the column
    if (!ce_n && we_n && !we_d && ale)
    begin
      ac <= ac + 1;
      if (ac == 0)
        col <= io_out;
    end
    if (!ce_n && we_n && !we_d && cle)
    begin
      cmd <= io_out;
      ac <= 0;
      nb <= '0;
      if (io_out inside {8'h30, 8'h10, 8'h11, 8'h15, 8'hd0, 8'hff})
        bsy <= slow ? 200 : 30;
    end
    if (read_strobe_n && !re_d)
      nb <= nb + 8'h1;
  end
endmodule
`default_nettype wire

// ==== tb/multibank_flash_command_ops_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module multibank_flash_command_ops_tb_top;
  import mfc_pkg::*;
  logic        ref_clk = 1'h0, nrst = 1'h0, cmd_valid = 1'h0, wr_valid = 1'h0, slow = 1'h0;
  logic        cmd_ready, cmd_err, busy_timeout, wr_ready, rd_valid, ce_n, cle, ale, we_n;
  logic        read_strobe_n, io_oe, ready_busy, deep_standby_reset_n;
  mfc_op_t     cmd_op = OP_STATUS;
  logic [2:0]  cmd_sel = '0;
  logic [1:0]  cmd_bank = '0;
  logic [31:0] cmd_addr = '0, seed = 32'ha36d;
  logic [11:0] cmd_len = '0;
  logic [7:0]  wr_data = '0, rd_data, io_out, io_in;
  logic [7:0]  exp_q[$];
  logic        err_q[$];
  int          num_errors = 0, check_count = 0, cyc = 0, tmo = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  mfc_host #(.TR_CYC(64)) i_mfc_host (.ref_clk, .nrst, .cmd_valid, .cmd_op, .cmd_sel,
    .cmd_bank, .cmd_addr, .cmd_len, .cmd_ready, .cmd_err, .busy_timeout, .wr_valid,
    .wr_data, .wr_ready, .rd_data, .rd_valid, .ce_n, .cle, .ale, .we_n, .read_strobe_n,
    .io_out, .io_oe, .io_in, .ready_busy, .deep_standby_reset_n);
  mfc_flash_model i_mfc_flash_model (.ref_clk, .ce_n, .cle, .ale, .we_n, .read_strobe_n,
    .io_out, .slow, .io_in, .ready_busy);
  task automatic rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic issue(input mfc_op_t o, input int s, input logic [31:0] a, input int l);
    do @(negedge ref_clk); while (cmd_ready !== 1'h1);
    @(posedge ref_clk);
    cmd_valid <= 1'h1;
    cmd_op <= o;
    cmd_sel <= 3'(s);
    cmd_addr <= a;
    cmd_bank <= a[1:0];
    cmd_len <= 12'(l);
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      summarize();
    end
    if (busy_timeout === 1'h1)
      tmo++;
    if (rd_valid === 1'h1)
      chk("rd_data", exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data, rd_data);
    if (cmd_err === 1'h1)
    begin
      chk("cmd_err", 8'(err_q.size() > 0), 8'h1);
      if (err_q.size() > 0)
        void'(err_q.pop_front());
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'h1;
    for (n = 0; n < 7; n++)
    begin
      exp_q.push_back((8'h70 + 8'(n)) ^ 8'h5a);
      issue(OP_STATUS, n, '0, 1);
    end
    err_q.push_back(1'h1);
    issue(OP_STATUS, 7, '0, 1);
    for (n = 0; n < 3; n++)
    begin
      rnd();
      for (int k = 0; k < n + 3; k++)
        exp_q.push_back(seed[7:0] + 8'(k));
      issue(n > 0 ? OP_RAND_OUT : OP_READ, 0, seed, n + 3);
    end
    wr_valid <= 1'h1;
    n = 0;
    repeat (12)
    begin
      @(posedge ref_clk);
      if (wr_ready === 1'h1)
        n++;
      rnd();
      wr_data <= seed[7:0];
    end
    wr_valid <= 1'h0;
    chk("fifo_fill", 8'(FIFO_WORDS), 8'(n));
    issue(OP_LOAD, 0, 32'h1, 4);
    err_q.push_back(1'h1);
    issue(OP_STATUS, 0, '0, 1);
    issue(OP_CONFIRM, 2, '0, 1);
    issue(OP_LOAD, 0, 32'h1, 4);
    err_q.push_back(1'h1);
    issue(OP_CONFIRM, 2, '0, 1);
    issue(OP_CONFIRM, 0, '0, 1);
    wr_valid <= 1'h1;
    issue(OP_LOAD, 0, 32'h0, 2);
    issue(OP_CONFIRM, 1, '0, 1);
    issue(OP_LOAD, 0, 32'h1, 2);
    for (n = 0; n < 4; n++)
    begin
      if (n == 3)
        err_q.push_back(1'h1);
      issue(OP_RAND_IN, 0, seed, 1);
    end
    issue(OP_CONFIRM, 1, '0, 1);
    issue(OP_LOAD, 0, 32'h2, 1);
    issue(OP_CONFIRM, 1, '0, 1);
    issue(OP_LOAD, 0, 32'h3, 1);
    err_q.push_back(1'h1);
    issue(OP_CONFIRM, 1, '0, 1);
    wr_valid <= 1'h0;
    issue(OP_CONFIRM, 0, '0, 1);
    for (n = 0; n < 4; n++)
    begin
      if (n == 3)
        err_q.push_back(1'h1);
      issue(OP_ERASE, 1, seed, 1);
    end
    issue(OP_ERASE, 0, seed, 1);
    slow <= 1'h1;
    issue(OP_READ, 0, seed, 2);
    err_q.push_back(1'h1);
    issue(OP_READ, 0, seed, 2);
    exp_q.push_back(8'h70 ^ 8'h5a);
    issue(OP_STATUS, 0, '0, 1);
    wait (ready_busy === 1'h1);
    slow <= 1'h0;
    @(posedge ref_clk);
    nrst <= 1'h0;
    repeat (3) @(posedge ref_clk);
    chk("rst_ready", 8'h0, 8'(cmd_ready));
    chk("rst_standby", 8'h0, 8'(deep_standby_reset_n));
    nrst <= 1'h1;
    exp_q.push_back(8'h71 ^ 8'h5a);
    issue(OP_STATUS, 1, '0, 1);
    issue(OP_RESET, 0, '0, 1);
    do @(negedge ref_clk); while (cmd_ready !== 1'h1);
    repeat (20) @(posedge ref_clk);
    chk("timeouts", 8'h1, 8'(tmo));
    chk("left_bytes", 8'h0, 8'(exp_q.size()));
    chk("left_errs", 8'h0, 8'(err_q.size()));
    chk("standby", 8'h1, 8'(deep_standby_reset_n));
    chk("io_oe_idle", 8'h0, 8'(io_oe));
    summarize();
  end
endmodule
`default_nettype wire
